// ---- pwm3_map.svh ----
// register offsets, field positions and reset values of the pwm block
`ifndef PWM3_MAP_SVH
`define PWM3_MAP_SVH
`define PWM_OFS_HALF_PERIOD 8'h00
`define PWM_OFS_DEAD_TIME   8'h01
`define PWM_OFS_MIN_PULSE   8'h02
`define PWM_OFS_DUTY_A      8'h03
`define PWM_OFS_DUTY_B      8'h04
`define PWM_OFS_DUTY_C      8'h05
`define PWM_OFS_SEGMENT     8'h06
`define PWM_OFS_GATE        8'h07
`define PWM_OFS_MODE        8'h08
`define PWM_OFS_SYNC_WIDTH  8'h09
`define PWM_OFS_SW_TRIP     8'h0A
`define PWM_OFS_STATUS      8'h0B
`define PWM_OFS_SHUT_CLEAR  8'h0C
`define PWM_MODE_DOUBLE_BIT 6
`define PWM_STAT_TRIP_BIT   0
`define PWM_STAT_SHUT_BIT   1
`define PWM_STAT_HALF_BIT   3
`define PWM_SEG_XOVER_LSB   6
`define PWM_GATE_HI_EN_BIT  8
`define PWM_GATE_LO_EN_BIT  9
`define PWM_RST_HALF_PERIOD 16'h0000
`define PWM_RST_DEAD_TIME   10'h000
`define PWM_RST_MIN_PULSE   10'h000
`define PWM_RST_DUTY        16'h0000
`define PWM_RST_SEGMENT     9'h03F
`define PWM_RST_GATE        10'h000
`define PWM_RST_MODE        16'h0000
`define PWM_RST_SYNC_WIDTH  8'h27
`endif

// ---- pwm3_pkg.sv ----
// types shared by the three-phase pwm generator
package pwm3_pkg;
    typedef enum logic [0:0] {
        HALF_FIRST  = 1'b0,
        HALF_SECOND = 1'b1
    } half_type;
    typedef logic [15:0] word_type;
endpackage

// ---- three_phase_pwm_generator.sv ----
// three-phase center-based pwm generator with shutdown and gate chopping
// What this block does
// RL1: six active-high outputs, three complementary pairs
// RL2: period, dead time, min pulse registers
// RL3: one duty register per phase pair
// RL4: one enable bit per output
// RL5: crossover bit swaps high and low
// RL6: 8-bit field sets chopping frequency
// RL7: separate chop enables, high and low
// RL8: mode bit 6 selects double update
// RL9: single update latches once per period
// RL10: double update latches again at midpoint
// RL11: sync at start, also midpoint if double
// RL12: sync width set by register
// RL13: trip pin low forces outputs off
// RL14: overcurrent sense low shuts outputs
// RL15: hardware shutdown path is unclocked
// RL16: software trip write shuts outputs
// RL17: status shows trip level, half period
// RL18: shutdown sources combined, reset timing
// RL19: sync and shutdown interrupt pulses
// RL20: 17-bit timer, center-based dead-time pairs
// RL21: period value is half period ticks
// RL22: period accepts values up to 0xffff
// RL23: 10-bit dead time, twice value ticks
// RL24: sync width value plus one, reset 0x27
// RL25: sync edge latches config, duty, segment
// RL26: status bit 3 marks second half
// RL27: on-time twice duty minus dead, clamped
`timescale 1ns/100ps
`include "pwm3_map.svh"
module three_phase_pwm_generator
    import pwm3_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    input  wire logic [7:0]  dm_addr,
    input  wire logic        dm_wr,
    input  wire logic        dm_rd,
    input  wire logic [15:0] dm_wdata,
    output logic      [15:0] dm_rdata,
    input  wire logic        trip_input_n,
    input  wire logic        current_sense_input,
    output logic             phase_a_high_out,
    output logic             phase_a_low_out,
    output logic             phase_b_high_out,
    output logic             phase_b_low_out,
    output logic             phase_c_high_out,
    output logic             phase_c_low_out,
    output logic             period_sync_pulse,
    output logic             sync_irq,
    output logic             shutdown_irq
);

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    word_type    half_period_q;
    logic [9:0]  dead_time_q;
    logic [9:0]  min_pulse_q;
    word_type    duty_q [3];
    logic [8:0]  segment_q;
    logic [9:0]  gate_q;
    word_type    mode_q;
    logic [7:0]  sync_width_q;
    logic        wr_swt;
    logic        wr_clr;

    assign wr_swt = dm_wr && (dm_addr == `PWM_OFS_SW_TRIP);
    assign wr_clr = dm_wr && (dm_addr == `PWM_OFS_SHUT_CLEAR);

    // register writes; data lands in shadows only at a sync edge
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            half_period_q <= `PWM_RST_HALF_PERIOD;
            dead_time_q   <= `PWM_RST_DEAD_TIME;
            min_pulse_q   <= `PWM_RST_MIN_PULSE;
            duty_q[0]     <= `PWM_RST_DUTY;
            duty_q[1]     <= `PWM_RST_DUTY;
            duty_q[2]     <= `PWM_RST_DUTY;
            segment_q     <= `PWM_RST_SEGMENT;
            gate_q        <= `PWM_RST_GATE;
            mode_q        <= `PWM_RST_MODE;
            sync_width_q  <= `PWM_RST_SYNC_WIDTH; // see RL24
        end else if (dm_wr) begin
            case (dm_addr)
                `PWM_OFS_HALF_PERIOD: half_period_q <= dm_wdata; // see RL22
                `PWM_OFS_DEAD_TIME:   dead_time_q <= dm_wdata[9:0]; // see RL2
                `PWM_OFS_MIN_PULSE:   min_pulse_q <= dm_wdata[9:0];
                `PWM_OFS_DUTY_A:      duty_q[0] <= dm_wdata; // see RL3
                `PWM_OFS_DUTY_B:      duty_q[1] <= dm_wdata;
                `PWM_OFS_DUTY_C:      duty_q[2] <= dm_wdata;
                `PWM_OFS_SEGMENT:     segment_q <= dm_wdata[8:0];
                `PWM_OFS_GATE:        gate_q <= dm_wdata[9:0];
                `PWM_OFS_MODE:        mode_q <= dm_wdata;
                `PWM_OFS_SYNC_WIDTH: sync_width_q <= dm_wdata[7:0]; // see RL12
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // shutdown controller
    // ------------------------------------------------------------
    logic shut_q;
    logic shut_src;
    logic shut_prev_q;

    // pins are level sources; software write is a one-shot source
    assign shut_src = !trip_input_n || !current_sense_input || wr_swt;

    // sticky shutdown; a new source beats a clear in the same cycle
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            shut_q <= 1'b0;
        end else if (shut_src) begin
            shut_q <= 1'b1; // see RL16, RL18
        end else if (wr_clr) begin
            shut_q <= 1'b0;
        end
    end

    // one-cycle interrupt on each new shutdown
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            shut_prev_q <= 1'b0;
        end else begin
            shut_prev_q <= shut_q;
        end
    end
    assign shutdown_irq = shut_q && !shut_prev_q; // see RL19

    // ------------------------------------------------------------
    // timing unit
    // ------------------------------------------------------------
    logic [16:0] tick_q;
    logic [16:0] tick_d;
    word_type    tm_s_q;
    logic [9:0]  dt_s_q;
    logic [9:0]  pd_s_q;
    word_type    duty_s_q [3];
    logic [8:0]  seg_s_q;
    logic        dbl_mode;
    logic        at_start;
    logic        at_mid;
    logic        latch_ev;
    logic        second_half;
    half_type    half_q;

    assign dbl_mode    = mode_q[`PWM_MODE_DOUBLE_BIT]; // see RL8
    assign second_half = (tick_q >= {1'b0, tm_s_q});
    assign at_start    = !shut_q && (tick_q == 17'h0_0000);
    // midpoint only counts once a real period is loaded
    assign at_mid      = !shut_q && (tm_s_q != 16'h0000)
                         && (tick_q == {1'b0, tm_s_q});
    assign latch_ev    = at_start || (dbl_mode && at_mid); // see RL9, RL10

    // full period is twice the half-period count
    always_comb begin
        tick_d = tick_q + 17'h0_0001;
        if (tick_d >= {tm_s_q, 1'b0}) begin
            tick_d = 17'h0_0000; // see RL21
        end
    end

    // shutdown holds the counter at period start
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            tick_q <= 17'h0_0000;
        end else if (shut_q) begin
            tick_q <= 17'h0_0000; // see RL18
        end else begin
            tick_q <= tick_d; // see RL20
        end
    end

    // shadow copies refresh on every sync edge
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            tm_s_q      <= `PWM_RST_HALF_PERIOD;
            dt_s_q      <= `PWM_RST_DEAD_TIME;
            pd_s_q      <= `PWM_RST_MIN_PULSE;
            duty_s_q[0] <= `PWM_RST_DUTY;
            duty_s_q[1] <= `PWM_RST_DUTY;
            duty_s_q[2] <= `PWM_RST_DUTY;
            seg_s_q     <= `PWM_RST_SEGMENT;
        end else if (latch_ev) begin
            tm_s_q      <= half_period_q; // see RL25
            dt_s_q      <= dead_time_q;
            pd_s_q      <= min_pulse_q;
            duty_s_q[0] <= duty_q[0];
            duty_s_q[1] <= duty_q[1];
            duty_s_q[2] <= duty_q[2];
            seg_s_q     <= segment_q;
        end
    end

    // half indicator: clear at start, set at midpoint
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            half_q <= HALF_FIRST;
        end else if (at_start) begin
            half_q <= HALF_FIRST;
        end else if (at_mid) begin
            half_q <= HALF_SECOND; // see RL26
        end
    end

    // ------------------------------------------------------------
    // sync pulse
    // ------------------------------------------------------------
    logic [8:0] sync_cnt_q;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync_cnt_q <= 9'h000;
        end else if (latch_ev) begin
            sync_cnt_q <= {1'b0, sync_width_q} + 9'h001; // see RL24
        end else if (sync_cnt_q != 9'h000) begin
            sync_cnt_q <= sync_cnt_q - 9'h001;
        end
    end
    assign period_sync_pulse = (sync_cnt_q != 9'h000); // see RL11
    assign sync_irq          = latch_ev; // see RL19

    // ------------------------------------------------------------
    // per-phase edge compare and output control
    // ------------------------------------------------------------
    // per-half on-time, clamped to [0, tm], narrow pulses dropped
    function automatic logic [16:0] clamp_on(
        input logic signed [18:0] v,
        input logic [15:0]        tm,
        input logic [9:0]         pd
    );
        logic [16:0] r;
        r = 17'h0_0000;
        if (v <= 19'sd0) begin
            r = 17'h0_0000;
        end else if (v >= $signed({3'b000, tm})) begin
            r = {1'b0, tm};
        end else begin
            r = v[16:0];
        end
        if ((r < {7'h00, pd}) && (r != {1'b0, tm})) begin
            r = 17'h0_0000;
        end
        return r;
    endfunction

    logic [2:0] raw_hi;
    logic [2:0] raw_lo;
    logic [5:0] mixed;
    logic [5:0] out_q;
    logic [16:0] t2;

    assign t2 = tick_q - {1'b0, tm_s_q};

    genvar ph;
    generate
        for (ph = 0; ph < 3; ph++) begin : g_phase
            logic [16:0] hon;
            logic [16:0] lon;
            logic [16:0] tm17;
            // edges move away from duty instant by dead time
            assign hon = clamp_on($signed({3'b000, duty_s_q[ph]})
                         - $signed({9'h000, dt_s_q}), tm_s_q, pd_s_q);
            assign lon = clamp_on($signed({3'b000, tm_s_q})
                         - $signed({3'b000, duty_s_q[ph]})
                         - $signed({9'h000, dt_s_q}), tm_s_q, pd_s_q);
            assign tm17 = {1'b0, tm_s_q};
            // high centred on the period midpoint, low at both ends
            always_comb begin
                if (!second_half) begin
                    raw_hi[ph] = (tick_q + hon >= tm17); // see RL27, RL23
                    raw_lo[ph] = (tick_q < lon);
                end else begin
                    raw_hi[ph] = (t2 < hon);
                    raw_lo[ph] = (t2 + lon >= tm17);
                end
            end
        end
    endgenerate

    // chopping divider: field+1 ticks per half wave
    logic [7:0] chop_cnt_q;
    logic       chop_q;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            chop_cnt_q <= 8'h00;
            chop_q     <= 1'b0;
        end else if (chop_cnt_q >= gate_q[7:0]) begin
            chop_cnt_q <= 8'h00; // see RL6
            chop_q     <= !chop_q;
        end else begin
            chop_cnt_q <= chop_cnt_q + 8'h01;
        end
    end

    // crossover, enables and chop mix; even bits high, odd bits low
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            logic h;
            logic l;
            h = raw_hi[i];
            l = raw_lo[i];
            if (seg_s_q[`PWM_SEG_XOVER_LSB + i]) begin
                h = raw_lo[i]; // see RL5
                l = raw_hi[i];
            end
            h = h && seg_s_q[2*i]; // see RL4
            l = l && seg_s_q[2*i+1];
            if (gate_q[`PWM_GATE_HI_EN_BIT]) begin
                h = h && chop_q; // see RL7
            end
            if (gate_q[`PWM_GATE_LO_EN_BIT]) begin
                l = l && chop_q;
            end
            mixed[2*i]   = h;
            mixed[2*i+1] = l;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            out_q <= 6'h00;
        end else if (shut_q) begin
            out_q <= 6'h00;
        end else begin
            out_q <= mixed;
        end
    end

    // hardware trip paths bypass every flop so a dead clock still
    // turns the inverter off
    logic hw_ok;
    assign hw_ok = trip_input_n && current_sense_input && !shut_q;
    assign phase_a_high_out = out_q[0] && hw_ok; // see RL13, RL14, RL15
    assign phase_a_low_out  = out_q[1] && hw_ok; // see RL1
    assign phase_b_high_out = out_q[2] && hw_ok;
    assign phase_b_low_out  = out_q[3] && hw_ok;
    assign phase_c_high_out = out_q[4] && hw_ok;
    assign phase_c_low_out  = out_q[5] && hw_ok;

    // ------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------
    // read data appears the cycle after the strobe
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            dm_rdata <= 16'h0000;
        end else if (dm_rd) begin
            case (dm_addr)
                `PWM_OFS_HALF_PERIOD: dm_rdata <= half_period_q;
                `PWM_OFS_DEAD_TIME:   dm_rdata <= {6'h00, dead_time_q};
                `PWM_OFS_MIN_PULSE:   dm_rdata <= {6'h00, min_pulse_q};
                `PWM_OFS_DUTY_A:      dm_rdata <= duty_q[0];
                `PWM_OFS_DUTY_B:      dm_rdata <= duty_q[1];
                `PWM_OFS_DUTY_C:      dm_rdata <= duty_q[2];
                `PWM_OFS_SEGMENT:     dm_rdata <= {7'h00, segment_q};
                `PWM_OFS_GATE:        dm_rdata <= {6'h00, gate_q};
                `PWM_OFS_MODE:        dm_rdata <= mode_q;
                `PWM_OFS_SYNC_WIDTH:  dm_rdata <= {8'h00, sync_width_q};
                `PWM_OFS_STATUS: begin
                    dm_rdata <= 16'h0000; // see RL17
                    dm_rdata[`PWM_STAT_TRIP_BIT] <= trip_input_n;
                    dm_rdata[`PWM_STAT_SHUT_BIT] <= shut_q;
                    dm_rdata[`PWM_STAT_HALF_BIT] <= half_q;
                end
                default: dm_rdata <= 16'h0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_mid_hit;
        dbl_mode && at_mid;
    endsequence
    sequence s_half_set;
        half_q == HALF_SECOND;
    endsequence

    property p_trip_off;
        !trip_input_n |-> !phase_a_high_out && !phase_a_low_out
            && !phase_b_high_out && !phase_c_high_out;
    endproperty
    a_trip_off: assert property (p_trip_off) // see RL13
        else $error("outputs on while trip pin low");

    property p_sense_off;
        !current_sense_input |-> !phase_b_low_out && !phase_c_low_out;
    endproperty
    a_sense_off: assert property (p_sense_off) // see RL14
        else $error("outputs on during overcurrent");

    property p_swt;
        // out_q catches up one cycle after the latch; the pins drop at once
        wr_swt |=> shut_q && !phase_a_high_out
            ##1 out_q == 6'h00 && shutdown_irq == 1'b0;
    endproperty
    a_swt: assert property (p_swt) // see RL16
        else $error("software trip did not shut down");

    property p_timer_reset;
        // a clear may end shutdown at the next edge, so sync is checked now
        shut_q |-> !sync_irq ##1 tick_q == 17'h0_0000;
    endproperty
    a_timer_reset: assert property (p_timer_reset) // see RL18
        else $error("timer not held during shutdown");

    property p_single_once;
        latch_ev && !dbl_mode |-> tick_q == 17'h0_0000;
    endproperty
    a_single_once: assert property (p_single_once) // see RL9
        else $error("single mode latched away from start");

    property p_dbl_mid;
        s_mid_hit |-> latch_ev ##1 s_half_set;
    endproperty
    a_dbl_mid: assert property (p_dbl_mid) // see RL10, RL26
        else $error("midpoint update or half bit missing");

    property p_sync_width;
        latch_ev |=> sync_cnt_q == {1'b0, $past(sync_width_q)} + 9'h001
            && period_sync_pulse;
    endproperty
    a_sync_width: assert property (p_sync_width) // see RL24
        else $error("sync width not value plus one");

    property p_latch;
        latch_ev |=> tm_s_q == $past(half_period_q)
            && duty_s_q[0] == $past(duty_q[0]);
    endproperty
    a_latch: assert property (p_latch) // see RL25
        else $error("shadow not loaded at sync");

    property p_wrap;
        !shut_q && tm_s_q != 16'h0000 |-> tick_q < {tm_s_q, 1'b0};
    endproperty
    a_wrap: assert property (p_wrap) // see RL21
        else $error("tick beyond full period");

endmodule

// ---- inverter_drive_model.sv ----
// far-side model: gate drivers with on-time counters and a current comparator
`timescale 1ns/100ps
module inverter_drive_model (
    input  wire logic            ref_clk,
    input  wire logic            clear_counts,
    input  wire logic            fault_cmd,
    input  wire logic [5:0]      gate_in,
    input  wire logic            period_sync_pulse,
    input  wire logic            sync_irq,
    input  wire logic            shutdown_irq,
    output logic                 current_sense_input,
    output logic      [9:0][7:0] counts,
    output logic                 shoot_through
);
    logic       a_high_last_q;
    logic [9:0] hit;

    // comparator stays above trip level unless the bench asks for a fault
    assign current_sense_input = ~fault_cmd;

    // --------------------------------------------------------------
    // activity counters, cleared by the bench before each window
    // --------------------------------------------------------------
    // one bit per watched event; bit 8 is a rising edge of the a high gate
    assign hit = {shutdown_irq, gate_in[0] & ~a_high_last_q, sync_irq,
                  period_sync_pulse, gate_in};

    // counting on the rising edge sees settled registered gate levels
    always_ff @(posedge ref_clk) begin
        a_high_last_q <= gate_in[0];
        for (int i = 0; i < 10; i++) begin
            counts[i] <= clear_counts ? 8'h00 : counts[i] + 8'(hit[i]);
        end
    end

    // both switches of a leg on at once would short the dc link
    always_ff @(posedge ref_clk) begin
        if (clear_counts) begin
            shoot_through <= 1'b0;
        end else if (|(gate_in & {gate_in[4], gate_in[5], gate_in[2],
                                  gate_in[3], gate_in[0], gate_in[1]})) begin
            shoot_through <= 1'b1;
        end
    end
endmodule

// ---- three_phase_pwm_generator_tb.sv ----
// self-checking bench for the three-phase pwm generator
`timescale 1ns/100ps
`include "pwm3_map.svh"
module three_phase_pwm_generator_tb
    import pwm3_pkg::*;
    ;
    logic            ref_clk = 1'b0;
    logic            arst_n = 1'b0;
    logic [7:0]      dm_addr = 8'h00;
    logic            dm_wr = 1'b0;
    logic            dm_rd = 1'b0;
    word_type        dm_wdata = 16'h0000;
    word_type        dm_rdata;
    logic            trip_input_n = 1'b1;
    logic            current_sense_input;
    logic [5:0]      gates;
    logic            period_sync_pulse;
    logic            sync_irq;
    logic            shutdown_irq;
    logic            clear_counts = 1'b1;
    logic            fault_cmd = 1'b0;
    logic [9:0][7:0] counts;
    logic            shoot_through;
    int              n_mismatch = 0;
    int              comparisons = 0;
    int              k;

    // 250 MHz clock
    always #2 ref_clk = ~ref_clk;

    three_phase_pwm_generator three_phase_pwm_generator_i (
        .ref_clk             (ref_clk),
        .arst_n              (arst_n),
        .dm_addr             (dm_addr),
        .dm_wr               (dm_wr),
        .dm_rd               (dm_rd),
        .dm_wdata            (dm_wdata),
        .dm_rdata            (dm_rdata),
        .trip_input_n        (trip_input_n),
        .current_sense_input (current_sense_input),
        .phase_a_high_out    (gates[0]),
        .phase_a_low_out     (gates[1]),
        .phase_b_high_out    (gates[2]),
        .phase_b_low_out     (gates[3]),
        .phase_c_high_out    (gates[4]),
        .phase_c_low_out     (gates[5]),
        .period_sync_pulse   (period_sync_pulse),
        .sync_irq            (sync_irq),
        .shutdown_irq        (shutdown_irq)
    );

    inverter_drive_model inverter_drive_model_i (
        .ref_clk             (ref_clk),
        .clear_counts        (clear_counts),
        .fault_cmd           (fault_cmd),
        .gate_in             (gates),
        .period_sync_pulse   (period_sync_pulse),
        .sync_irq            (sync_irq),
        .shutdown_irq        (shutdown_irq),
        .current_sense_input (current_sense_input),
        .counts              (counts),
        .shoot_through       (shoot_through)
    );

    // --------------------------------------------------------------
    // bus and compare tasks, entered at a falling edge except the gate check after a trip
    // --------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        comparisons++;
        if (seen !== want) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    // extra idle cycle so the strobe is never re-raised in the same step
    task automatic wr(input logic [7:0] a, input word_type d);
        dm_addr = a;
        dm_wdata = d;
        dm_wr = 1'b1;
        @(negedge ref_clk);
        dm_wr = 1'b0;
        @(negedge ref_clk);
    endtask

    task automatic rd_chk(input logic [7:0] a, input word_type mask,
                          input word_type want);
        dm_addr = a;
        dm_rd = 1'b1;
        @(negedge ref_clk);
        dm_rd = 1'b0;
        check(dm_rdata & mask, want);
        @(negedge ref_clk);
    endtask

    // align to a latch, skip one period, then count over one full period
    task automatic measure();
        int n;
        n = 0;
        while (sync_irq !== 1'b1 && n < 200) begin
            @(negedge ref_clk);
            n++;
        end
        check(16'(n < 200), 16'h0001);
        repeat (16) @(negedge ref_clk);
        clear_counts = 1'b1;
        @(negedge ref_clk);
        clear_counts = 1'b0;
        repeat (16) @(negedge ref_clk);
    endtask

    task automatic check_gates(input logic [5:0][7:0] want);
        for (int i = 0; i < 6; i++) begin
            check(16'(counts[i]), 16'(want[i]));
        end
        check(16'(shoot_through), 16'h0000);
    endtask

    task automatic give_verdict();
        $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // hang guard, far beyond the fewer than a thousand cycles the tests need
    initial begin
        #100000;
        n_mismatch++;
        give_verdict();
    end

    // --------------------------------------------------------------
    // test sequence
    // --------------------------------------------------------------
    initial begin
        repeat (20) @(negedge ref_clk);
        arst_n = 1'b1;
        @(negedge ref_clk);
        rd_chk(`PWM_OFS_SYNC_WIDTH, 16'hffff, 16'h0027);
        rd_chk(`PWM_OFS_SEGMENT, 16'hffff, 16'h003f);
        rd_chk(`PWM_OFS_MODE, 16'hffff, 16'h0000);
        rd_chk(8'h20, 16'hffff, 16'h0000);
        // park the timer in shutdown so the extreme values never latch;
        // a 0xffff half period would otherwise run 131070 ticks
        wr(`PWM_OFS_SW_TRIP, 16'h0001);
        wr(`PWM_OFS_DEAD_TIME, 16'hffff);
        rd_chk(`PWM_OFS_DEAD_TIME, 16'hffff, 16'h03ff);
        wr(`PWM_OFS_HALF_PERIOD, 16'hffff);
        rd_chk(`PWM_OFS_HALF_PERIOD, 16'hffff, 16'hffff);
        // tm 8, dead 1: on-times 2*(duty-1) high, 2*(8-duty-1) low
        wr(`PWM_OFS_HALF_PERIOD, 16'h0008);
        wr(`PWM_OFS_DEAD_TIME, 16'h0001);
        wr(`PWM_OFS_DUTY_A, 16'h0005);
        wr(`PWM_OFS_DUTY_B, 16'h0004);
        wr(`PWM_OFS_DUTY_C, 16'h0008);
        wr(`PWM_OFS_SYNC_WIDTH, 16'h0002);
        // leaving shutdown restarts the period with the new values
        wr(`PWM_OFS_SHUT_CLEAR, 16'h0001);
        measure();
        check_gates({8'h00, 8'h0e, 8'h06, 8'h06, 8'h04, 8'h08});
        check(16'(counts[6]), 16'h0003);
        check(16'(counts[7]), 16'h0001);
        wr(`PWM_OFS_MODE, 16'h0040);
        measure();
        check(16'(counts[7]), 16'h0002);
        check(16'(counts[6]), 16'h0006);
        check_gates({8'h00, 8'h0e, 8'h06, 8'h06, 8'h04, 8'h08});
        wr(`PWM_OFS_MODE, 16'h0000);
        wr(`PWM_OFS_SEGMENT, 16'h003e);
        measure();
        check_gates({8'h00, 8'h0e, 8'h06, 8'h06, 8'h04, 8'h00});
        wr(`PWM_OFS_SEGMENT, 16'h007f);
        measure();
        check_gates({8'h00, 8'h0e, 8'h06, 8'h06, 8'h08, 8'h04});
        wr(`PWM_OFS_SEGMENT, 16'h003f);
        // on-times under the minimum are dropped
        wr(`PWM_OFS_MIN_PULSE, 16'h0004);
        measure();
        check_gates({8'h00, 8'h0e, 8'h00, 8'h00, 8'h00, 8'h08});
        wr(`PWM_OFS_MIN_PULSE, 16'h0000);
        // chop the high side only, low side on-time unchanged
        wr(`PWM_OFS_GATE, 16'h0101);
        measure();
        check(16'(counts[1]), 16'h0004);
        check(16'(counts[8] > 8'h01), 16'h0001);
        wr(`PWM_OFS_GATE, 16'h0000);
        // three shutdown sources: pin, comparator, software write
        for (int s = 0; s < 3; s++) begin
            measure();
            clear_counts = 1'b1;
            @(negedge ref_clk);
            clear_counts = 1'b0;
            k = 0;
            while (gates[4] !== 1'b1 && k < 40) begin
                @(negedge ref_clk);
                k++;
            end
            if (s == 0) trip_input_n = 1'b0;
            if (s == 1) fault_cmd = 1'b1;
            if (s == 2) wr(`PWM_OFS_SW_TRIP, 16'h0001);
            #1;
            check(16'(gates), 16'h0000);
            // for the pin and comparator the latch sets on the next edge; read status after it
            @(negedge ref_clk);
            rd_chk(`PWM_OFS_STATUS, 16'h0003,
                   (s == 0) ? 16'h0002 : 16'h0003);
            check(16'(counts[9]), 16'h0001);
            trip_input_n = 1'b1;
            fault_cmd = 1'b0;
            wr(`PWM_OFS_SHUT_CLEAR, 16'h0001);
            measure();
            check(16'(counts[4]), 16'h000e);
        end
        give_verdict();
    end
endmodule
